// ### core/snsp_status_protect.sv
// Status byte, write latch and array protection behind the serial port
`timescale 1ns/1ps

// Function
// - Status byte layout: enable, lock, zeros, guards, latch, busy
// - Busy bit reads one during save/restore
// - Status write changes only bits 2,3,6,7
// - Bits 4 and 5 read zero always
// - Serial writes refused once lock is set
// - Lock bit sets once, never clears
// - Guard, lock, enable, latch start at zero
// - Latch is zero after power-up
// - Normal status read shifts status after opcode
// - Fast status read needs one dummy byte
// - Status write is opcode plus eight bits
// - Write-type instructions ignored while latch clear
// - Latch-set instruction sets the latch
// - Completed write-type instruction clears the latch
// - Latch-clear takes effect at select release
// - Guard code picks none, quarter, half, all
// - Writes into guarded range are discarded
// - Guard pin matters only with enable set
// - Retained copy changes only on save completion
// - Status opcodes 05, 09 and 01
// - Latch opcodes 06 set, 04 clear
// - Most significant bit first, select falling starts
// - Guard pin low with enable rejects status write
module snsp_status_protect (
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              sys_rst_i,
   // Serial port
   input  wire logic              spi_sck_i,
   input  wire logic              spi_cs_n_i,
   input  wire logic              spi_mosi_i,
   output logic                   spi_miso_o,
   output logic                   spi_miso_oe_o,
   // Write guard pin, low means guard
   input  wire logic              guard_n_i,
   // Nonvolatile engine
   input  wire logic              busy_i,
   input  wire logic              save_done_i,
   input  wire logic              restore_done_i,
   // Forwarded writes and accepted specials
   output snsp_pkg::snsp_fwd_s    fwd_o,
   // Live and retained status
   output logic [7:0]             status_o,
   output logic [7:0]             nv_status_o
);
   import snsp_pkg::*;

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   function automatic logic is_write_type(input logic [7:0] op);
      case (op)
         STATUS_WRITE_CMD, ARRAY_WRITE_CMD, CLOCK_WRITE_CMD,
         SERIAL_WRITE_CMD, SAVE_CMD, RESTORE_CMD,
         AUTOSAVE_ON_CMD, AUTOSAVE_OFF_CMD: is_write_type = 1'b1;
         default:                           is_write_type = 1'b0;
      endcase
   endfunction

   function automatic logic is_special(input logic [7:0] op);
      case (op)
         SAVE_CMD, RESTORE_CMD, AUTOSAVE_ON_CMD,
         AUTOSAVE_OFF_CMD: is_special = 1'b1;
         default:          is_special = 1'b0;
      endcase
   endfunction

   function automatic logic in_guard(input logic [1:0] code, input logic [15:0] a);
      case (code)
         GUARD_NONE:    in_guard = 1'b0;
         GUARD_QUARTER: in_guard = (a >= QUARTER_BASE);
         GUARD_HALF:    in_guard = (a >= HALF_BASE);
         GUARD_ALL:     in_guard = 1'b1;
         default:       in_guard = 1'b1;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Pin edges
   // ---------------------------------------------------------------
   logic sck_reg;
   logic cs_n_reg;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sck_reg  <= 1'b0;
         cs_n_reg <= 1'b1;
      end else begin
         sck_reg  <= spi_sck_i;
         cs_n_reg <= spi_cs_n_i;
      end
   end

   assign sck_rise = spi_sck_i & ~sck_reg & ~spi_cs_n_i;
   assign sck_fall = ~spi_sck_i & sck_reg & ~spi_cs_n_i;
   assign cs_fall  = ~spi_cs_n_i & cs_n_reg;
   assign cs_rise  = spi_cs_n_i & ~cs_n_reg;

   // ---------------------------------------------------------------
   // Input shifter
   // ---------------------------------------------------------------
   logic [7:0] shift_reg;
   logic [2:0] bit_cnt_reg;
   logic       byte_done;
   logic [7:0] byte_val;

   assign byte_val  = {shift_reg[6:0], spi_mosi_i};
   assign byte_done = sck_rise & (bit_cnt_reg == LAST_BIT);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || cs_fall) begin
         shift_reg   <= 8'h00;
         bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
         shift_reg   <= byte_val;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // Instruction phase
   // ---------------------------------------------------------------
   snsp_phase_e phase_reg;
   logic [7:0]  op_reg;
   logic [1:0]  addr_left_reg;
   logic [15:0] addr_reg;
   logic        done_reg;
   logic        guard_q_reg;
   logic        pin_en_reg;
   logic        lock_reg;
   logic [1:0]  bp_reg;
   logic        latch_reg;
   logic        busy_reg;
   logic        sw_ok;

   // Guard pin is caught at selection so a change mid-frame has no effect
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         guard_q_reg <= 1'b0;
      end else if (cs_fall) begin
         guard_q_reg <= ~guard_n_i & pin_en_reg;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || cs_fall) begin
         phase_reg     <= PH_OPCODE;
         op_reg        <= 8'h00;
         addr_left_reg <= ADDR_NONE;
         addr_reg      <= 16'h0000;
         done_reg      <= 1'b0;
      end else if (byte_done) begin
         case (phase_reg)
            PH_OPCODE: begin
               op_reg <= byte_val;
               if (is_write_type(byte_val) && !latch_reg) begin
                  phase_reg <= PH_SKIP;
               end else begin
                  case (byte_val)
                     STATUS_READ_CMD:      phase_reg <= PH_OUT;
                     STATUS_FAST_READ_CMD: phase_reg <= PH_DUMMY;
                     STATUS_WRITE_CMD:     phase_reg <= PH_DATA;
                     SERIAL_WRITE_CMD:     phase_reg <= PH_DATA;
                     ARRAY_WRITE_CMD: begin
                        phase_reg     <= PH_ADDR;
                        addr_left_reg <= ADDR_ARRAY;
                     end
                     CLOCK_WRITE_CMD: begin
                        phase_reg     <= PH_ADDR;
                        addr_left_reg <= ADDR_CLOCK;
                     end
                     default: begin
                        phase_reg <= PH_SKIP;
                        done_reg  <= is_special(byte_val);
                     end
                  endcase
               end
            end
            PH_DUMMY: phase_reg <= PH_OUT;
            PH_ADDR: begin
               addr_reg      <= {addr_reg[7:0], byte_val};
               addr_left_reg <= addr_left_reg - 2'h1;
               if (addr_left_reg == ADDR_CLOCK) begin
                  phase_reg <= PH_DATA;
               end
            end
            PH_DATA: begin
               done_reg <= 1'b1;
               addr_reg <= addr_reg + 16'h0001;
               if (op_reg == STATUS_WRITE_CMD) begin
                  phase_reg <= PH_SKIP;
               end
            end
            PH_OUT:  phase_reg <= PH_OUT;
            PH_SKIP: phase_reg <= PH_SKIP;
            default: phase_reg <= PH_SKIP;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Status fields
   // ---------------------------------------------------------------
   assign sw_ok = byte_done && phase_reg == PH_DATA && op_reg == STATUS_WRITE_CMD
                  && !guard_q_reg;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_i;
      end
   end

   // Restore reloads guards and enable from the retained copy
   logic       pin_nv_reg;
   logic       lock_nv_reg;
   logic [1:0] bp_nv_reg;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pin_en_reg <= 1'b0;
         bp_reg     <= GUARD_NONE;
      end else if (sw_ok) begin
         pin_en_reg <= byte_val[ST_PIN_EN];
         bp_reg     <= byte_val[ST_BLOCK_HI:ST_BLOCK_LO];
      end else if (restore_done_i) begin
         pin_en_reg <= pin_nv_reg;
         bp_reg     <= bp_nv_reg;
      end
   end

   // Lock only ever ORs in, so no path can return it to zero
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         lock_reg <= 1'b0;
      end else if (sw_ok) begin
         lock_reg <= lock_reg | byte_val[ST_LOCK];
      end else if (restore_done_i) begin
         lock_reg <= lock_reg | lock_nv_reg;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         latch_reg <= 1'b0;
      end else if (byte_done && phase_reg == PH_OPCODE && byte_val == LATCH_SET_CMD) begin
         latch_reg <= 1'b1;
      end else if (cs_rise && op_reg == LATCH_CLEAR_CMD) begin
         latch_reg <= 1'b0;
      end else if (cs_rise && done_reg && is_write_type(op_reg)) begin
         latch_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pin_nv_reg  <= 1'b0;
         lock_nv_reg <= 1'b0;
         bp_nv_reg   <= GUARD_NONE;
      end else if (save_done_i) begin
         pin_nv_reg  <= pin_en_reg;
         lock_nv_reg <= lock_reg;
         bp_nv_reg   <= bp_reg;
      end
   end

   logic [7:0] status_now;
   assign status_now = {pin_en_reg, lock_reg, UNUSED_BITS, bp_reg, latch_reg, busy_reg};

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         status_o    <= 8'h00;
         nv_status_o <= 8'h00;
      end else begin
         status_o    <= status_now;
         nv_status_o <= {pin_nv_reg, lock_nv_reg, UNUSED_BITS, bp_nv_reg, 2'h0};
      end
   end

   // ---------------------------------------------------------------
   // Status shift-out
   // ---------------------------------------------------------------
   logic [7:0] tx_reg;
   logic [2:0] tx_cnt_reg;

   // Bits change on falling clock so the host samples on the rising one
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || cs_fall) begin
         tx_reg     <= 8'h00;
         tx_cnt_reg <= 3'h0;
         spi_miso_o <= 1'b0;
      end else if (phase_reg != PH_OUT) begin
         tx_reg     <= status_now;
         tx_cnt_reg <= 3'h0;
      end else if (sck_fall) begin
         spi_miso_o <= tx_reg[7];
         tx_cnt_reg <= tx_cnt_reg + 3'h1;
         tx_reg     <= (tx_cnt_reg == LAST_BIT) ? status_now : {tx_reg[6:0], 1'b0};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         spi_miso_oe_o <= 1'b0;
      end else begin
         spi_miso_oe_o <= ~spi_cs_n_i & (phase_reg == PH_OUT);
      end
   end

   // ---------------------------------------------------------------
   // Forwarded writes
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         fwd_o <= '0;
      end else begin
         fwd_o.valid <= 1'b0;
         fwd_o.op    <= op_reg;
         fwd_o.addr  <= addr_reg;
         fwd_o.data  <= byte_val;
         if (byte_done && phase_reg == PH_DATA) begin
            case (op_reg)
               ARRAY_WRITE_CMD:  fwd_o.valid <= ~in_guard(bp_reg, addr_reg);
               SERIAL_WRITE_CMD: fwd_o.valid <= ~lock_reg;
               CLOCK_WRITE_CMD:  fwd_o.valid <= 1'b1;
               default:          fwd_o.valid <= 1'b0;
            endcase
         end else if (cs_rise && done_reg && is_special(op_reg)) begin
            fwd_o.valid <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_set_cmd;
      byte_done && phase_reg == PH_OPCODE && byte_val == LATCH_SET_CMD;
   endsequence

   sequence s_clear_end;
      cs_rise && op_reg == LATCH_CLEAR_CMD;
   endsequence

   property p_layout;
      status_o[5:4] == UNUSED_BITS && status_o[ST_LATCH] == $past(latch_reg);
   endproperty
   a_layout: assert property (p_layout) else $error("status layout wrong");

   property p_busy;
      $rose(busy_i) |=> ##1 status_o[ST_BUSY];
   endproperty
   a_busy: assert property (p_busy) else $error("busy not reported");

   property p_lock_sticky;
      lock_reg |=> lock_reg;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

   property p_latch_set;
      s_set_cmd |=> latch_reg;
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch not set");

   property p_latch_clear;
      s_clear_end |=> !latch_reg;
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

   property p_guard_write;
      fwd_o.valid && fwd_o.op == ARRAY_WRITE_CMD |-> !in_guard($past(bp_reg), fwd_o.addr);
   endproperty
   a_guard_write: assert property (p_guard_write) else $error("guarded write");

   property p_serial_locked;
      fwd_o.valid && fwd_o.op == SERIAL_WRITE_CMD |-> !$past(lock_reg);
   endproperty
   a_serial_locked: assert property (p_serial_locked) else $error("locked serial");

   property p_nv_hold;
      !save_done_i |=> $stable(bp_nv_reg) && $stable(pin_nv_reg) && $stable(lock_nv_reg);
   endproperty
   a_nv_hold: assert property (p_nv_hold) else $error("retained copy moved");

   // Refused status write must leave every writable field as it was
   property p_pin_reject;
      byte_done && phase_reg == PH_DATA && op_reg == STATUS_WRITE_CMD && guard_q_reg
         && !restore_done_i |=> ##1 $stable(status_o[ST_PIN_EN:ST_BLOCK_LO]);
   endproperty
   a_pin_reject: assert property (p_pin_reject) else $error("guarded status write");

   property p_ignore_unlatched;
      byte_done && phase_reg == PH_OPCODE && is_write_type(byte_val) && !latch_reg
         |=> phase_reg == PH_SKIP;
   endproperty
   a_ignore_unlatched: assert property (p_ignore_unlatched) else $error("not ignored");

endmodule

// ### include/snsp_pkg.sv
// Shared constants and types for the serial status and protection block
package snsp_pkg;
   // ---------------------------------------------------------------
   // Instruction codes
   // ---------------------------------------------------------------
   localparam logic [7:0] STATUS_READ_CMD      = 8'h05;
   localparam logic [7:0] STATUS_FAST_READ_CMD = 8'h09;
   localparam logic [7:0] STATUS_WRITE_CMD     = 8'h01;
   localparam logic [7:0] LATCH_SET_CMD        = 8'h06;
   localparam logic [7:0] LATCH_CLEAR_CMD      = 8'h04;
   localparam logic [7:0] ARRAY_WRITE_CMD      = 8'h02;
   localparam logic [7:0] CLOCK_WRITE_CMD      = 8'h12;
   localparam logic [7:0] SAVE_CMD             = 8'h3c;
   localparam logic [7:0] RESTORE_CMD          = 8'h60;
   localparam logic [7:0] AUTOSAVE_ON_CMD      = 8'h59;
   localparam logic [7:0] AUTOSAVE_OFF_CMD     = 8'h19;
   localparam logic [7:0] SERIAL_WRITE_CMD     = 8'hc2;

   // ---------------------------------------------------------------
   // Status byte layout
   // ---------------------------------------------------------------
   localparam int ST_BUSY    = 0;
   localparam int ST_LATCH   = 1;
   localparam int ST_BLOCK_LO = 2;
   localparam int ST_BLOCK_HI = 3;
   localparam int ST_LOCK    = 6;
   localparam int ST_PIN_EN  = 7;
   localparam logic [1:0] UNUSED_BITS = 2'h0;

   // ---------------------------------------------------------------
   // Block guard codes and bounds
   // ---------------------------------------------------------------
   localparam logic [1:0]  GUARD_NONE    = 2'h0;
   localparam logic [1:0]  GUARD_QUARTER = 2'h1;
   localparam logic [1:0]  GUARD_HALF    = 2'h2;
   localparam logic [1:0]  GUARD_ALL     = 2'h3;
   localparam logic [15:0] QUARTER_BASE  = 16'hc000;
   localparam logic [15:0] HALF_BASE     = 16'h8000;

   // Shift counters
   localparam logic [2:0] LAST_BIT   = 3'h7;
   localparam logic [1:0] ADDR_ARRAY = 2'h2;
   localparam logic [1:0] ADDR_CLOCK = 2'h1;
   localparam logic [1:0] ADDR_NONE  = 2'h0;

   typedef enum logic [2:0] {
      PH_OPCODE, PH_DUMMY, PH_ADDR, PH_DATA, PH_OUT, PH_SKIP
   } snsp_phase_e;

   // One forwarded write byte or accepted special instruction
   typedef struct packed {
      logic        valid;
      logic [7:0]  op;
      logic [15:0] addr;
      logic [7:0]  data;
   } snsp_fwd_s;
endpackage

// ### verif/snsp_host_model.sv
// Serial host model that frames instructions toward the status block
`timescale 1ns/1ps

module snsp_host_model (
   // Clock
   input  wire logic sys_clk_i,
   // Serial port
   input  wire logic spi_miso_i,
   output logic      spi_sck_o,
   output logic      spi_cs_n_o,
   output logic      spi_mosi_o
);
   // ---------------------------------------------------------------
   // Frame engine
   // ---------------------------------------------------------------
   // Serial clock idles low between frames; four system cycles per bit
   // keep it well under half the system rate so every edge is seen
   initial begin
      spi_sck_o  = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
   end

   // Sends n bytes from tx, top byte first, returns the last byte heard
   task automatic frame(input logic [31:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      @(negedge sys_clk_i);
      spi_cs_n_o = 1'b0;
      for (int i = 0; i < 8 * n; i++) begin
         spi_mosi_o = tx[31 - i];
         repeat (2) @(negedge sys_clk_i);
         spi_sck_o = 1'b1;
         rx = {rx[6:0], spi_miso_i};
         repeat (2) @(negedge sys_clk_i);
         spi_sck_o = 1'b0;
      end
      repeat (2) @(negedge sys_clk_i);
      spi_cs_n_o = 1'b1;
      // A released data line must not keep showing its last bit
      spi_mosi_o = ~spi_mosi_o;
      repeat (4) @(negedge sys_clk_i);
   endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the status and protection block
`timescale 1ns/1ps

module tb;
   import snsp_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic       sys_clk_i, sys_rst_i, sck, cs_n, mosi, miso, oe;
   logic       guard_n_i, busy_i, save_done_i, restore_done_i;
   snsp_fwd_s  fwd_o, fwd_last;
   logic [7:0] status_o, nv_status_o, rx;
   int         err_total, compares, fwd_cnt, cyc, c0, oe_hits, c1;
   logic [15:0] addrs [6] = '{16'h0000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hffff};
   logic [7:0]  ops [6] = '{SAVE_CMD, RESTORE_CMD, AUTOSAVE_ON_CMD, AUTOSAVE_OFF_CMD,
                            CLOCK_WRITE_CMD, SERIAL_WRITE_CMD};
   int          lens [6] = '{1, 1, 1, 1, 3, 2};

   snsp_status_protect uut (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe), .guard_n_i(guard_n_i),
      .busy_i(busy_i), .save_done_i(save_done_i), .restore_done_i(restore_done_i),
      .fwd_o(fwd_o), .status_o(status_o), .nv_status_o(nv_status_o));

   snsp_host_model host (
      .sys_clk_i(sys_clk_i), .spi_miso_i(miso), .spi_sck_o(sck), .spi_cs_n_o(cs_n),
      .spi_mosi_o(mosi));

   // ---------------------------------------------------------------
   // Clock, watchdog and forward monitor
   // ---------------------------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i) begin
      cyc++;
      if (oe === 1'b1)
         oe_hits++;
      if (fwd_o.valid === 1'b1) begin
         fwd_cnt++;
         fwd_last = fwd_o;
      end
      // Whole run needs about 8400 cycles
      if (cyc == 60000) begin
         err_total++;
         close_out();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // Live byte, then the same byte through a normal and a fast read
   task automatic chk_status(input logic [7:0] exp);
      cmp("status", {8'h00, exp}, {8'h00, status_o});
      cmp("miso_oe_idle", 16'h0, {15'h0, oe});
      c1 = oe_hits;
      host.frame({STATUS_READ_CMD, 8'haa, 16'h0000}, 2, rx);
      cmp("status_read", {8'h00, exp}, {8'h00, rx});
      cmp("miso_oe_read", 16'h1, {15'h0, (oe_hits > c1)});
      host.frame({STATUS_FAST_READ_CMD, 8'h00, 8'h55, 8'h00}, 3, rx);
      cmp("status_fast_read", {8'h00, exp}, {8'h00, rx});
   endtask

   task automatic latch_on();
      host.frame({LATCH_SET_CMD, 24'h0}, 1, rx);
   endtask

   task automatic wr_status(input logic [7:0] d);
      latch_on();
      host.frame({STATUS_WRITE_CMD, d, 16'h0000}, 2, rx);
   endtask

   task automatic arr_wr(input logic [15:0] a, input logic ok);
      c0 = fwd_cnt;
      latch_on();
      host.frame({ARRAY_WRITE_CMD, a, 8'h5a}, 4, rx);
      cmp("fwd_count", 16'(c0 + int'(ok)), 16'(fwd_cnt));
      if (ok) begin
         cmp("fwd_addr", a, fwd_last.addr);
         cmp("fwd_data", 16'h005a, {8'h00, fwd_last.data});
      end
      cmp("latch", 16'h0, {15'h0, status_o[ST_LATCH]});
   endtask

   task automatic pulse(ref logic s);
      @(negedge sys_clk_i);
      s = 1'b1;
      @(negedge sys_clk_i);
      s = 1'b0;
      repeat (3) @(negedge sys_clk_i);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {err_total, compares, fwd_cnt, cyc, oe_hits, c1} = '0;
      fwd_last = '0;
      sys_rst_i = 1'b1;
      {busy_i, save_done_i, restore_done_i} = 3'b000;
      guard_n_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      chk_status(8'h00);
      cmp("retained", 16'h0, {8'h00, nv_status_o});
      host.frame({STATUS_WRITE_CMD, 8'h0c, 16'h0000}, 2, rx);
      chk_status(8'h00);
      latch_on();
      chk_status(8'h02);
      host.frame({LATCH_CLEAR_CMD, 24'h0}, 1, rx);
      chk_status(8'h00);
      // Guard pin low must not matter while the pin enable is clear
      guard_n_i = 1'b0;
      for (int c = 0; c < 4; c++) begin
         wr_status({4'h3, c[1:0], 2'h3});
         chk_status({4'h0, c[1:0], 2'h0});
         foreach (addrs[k])
            arr_wr(addrs[k], !(c == 3 || (c == 2 && addrs[k] >= 16'h8000) ||
                   (c == 1 && addrs[k] >= 16'hc000)));
      end
      guard_n_i = 1'b1;
      foreach (ops[k]) begin
         c0 = fwd_cnt;
         host.frame({ops[k], 8'h05, 8'h77, 8'h00}, lens[k], rx);
         cmp("refused_count", 16'(c0), 16'(fwd_cnt));
         latch_on();
         host.frame({ops[k], 8'h05, 8'h77, 8'h00}, lens[k], rx);
         cmp("fwd_count", 16'(c0 + 1), 16'(fwd_cnt));
         cmp("fwd_op", {8'h00, ops[k]}, {8'h00, fwd_last.op});
         cmp("latch", 16'h0, {15'h0, status_o[ST_LATCH]});
      end
      busy_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      chk_status(8'h0d);
      busy_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      wr_status(8'hc3);
      chk_status(8'hc0);
      cmp("retained", 16'h0, {8'h00, nv_status_o});
      pulse(save_done_i);
      cmp("retained", 16'h00c0, {8'h00, nv_status_o});
      guard_n_i = 1'b0;
      wr_status(8'h0c);
      chk_status(8'hc0);
      guard_n_i = 1'b1;
      wr_status(8'h00);
      chk_status(8'h40);
      c0 = fwd_cnt;
      latch_on();
      host.frame({SERIAL_WRITE_CMD, 8'h33, 16'h0000}, 2, rx);
      cmp("serial_fwd", 16'(c0), 16'(fwd_cnt));
      pulse(restore_done_i);
      chk_status(8'hc0);
      close_out();
   end
endmodule
